// File: cpo_pkg.sv
/*
  Shared types and constants for the clock pin output control block.
  Assumes a single 50 MHz system clock and no register bus.
*/
package cpo_pkg;

  // System clock period in ns, for reference by users of the block
  localparam int CPO_CLK_PERIOD_NS = 20;

  // Width of the free running divider counter
  localparam int CPO_DIV_W = 4;

  // Divider counter value after reset
  localparam logic [3:0] CPO_DIV_RESET = 4'h0;

  // Divide select field width
  localparam int CPO_SEL_W = 2;

  // Divide select value after reset (divide by two)
  localparam logic [1:0] CPO_SEL_RESET = 2'h0;

  // Bit positions of the two divide select inputs
  localparam int CPO_SEL_HI_POS = 1;
  localparam int CPO_SEL_LO_POS = 0;

  // Stages of the pin synchroniser
  localparam int CPO_SYNC_STAGES = 2;

  // Processing states of the device
  typedef enum logic [2:0] {
    CPO_NORMAL   = 3'b000,
    CPO_SLEEP    = 3'b001,
    CPO_SW_STBY  = 3'b010,
    CPO_HW_STBY  = 3'b011,
    CPO_ALL_STOP = 3'b100
  } cpo_state_type;

  // One driven pin: level and active low output enable
  typedef struct packed {
    logic out;
    logic oe_b;
  } cpo_pin_type;

  // Pin value after reset: released, high level
  localparam cpo_pin_type CPO_PIN_RESET = '{out: 1'b1, oe_b: 1'b1};

endpackage

// File: cpo_sync.sv
/*
  Two stage level synchroniser for an asynchronous pin.
  Assumes the input changes slowly compared with clk.
*/
`timescale 1ns/1ps
module cpo_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous level and its synchronised copy
  input wire logic async_in,
  output logic sync_out
);
  import cpo_pkg::*;

  // First stage, read only by the second stage
  logic meta_q;
  logic meta_d;
  // Second stage
  logic sync_q;
  logic sync_d;

  // Next values of both stages
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register both stages; reset to the released level
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: cpo_clock_pin_output_control.sv
/*
  Clock pin output control: drives the system clock pin and the memory
  clock pin from the divided system clock, gates them by stop bits and
  port direction, and sets each pin per processing state. Also guards
  the transfer controller halt bits and gates interrupt clearing of
  halted modules.
  Assumes control bits come from same-clock logic; only the hardware
  standby pin is asynchronous.
*/
// How it works
// - Stop bit set: pin high after bus cycle
// - Stop bit clear, direction output: clock driven
// - Direction zero: pin floats, stop ignored
// - Clock pin level per processing state
// - Memory stop: end of cycle, pin to port
// - Memory clock out regardless of direction
// - Memory pin level per processing state
// - No memory interface: pin is plain port
// - Software standby holds port pin levels
// - Halted module performs no interrupt clearing
// - Peripherals run from divided system clock
`timescale 1ns/1ps
module cpo_clock_pin_output_control
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Processing state and bus timing
  input wire cpo_pkg::cpo_state_type proc_state,
  input wire logic bus_cycle_end,
  input wire logic hw_standby_pin_b,
  // Clock control bits
  input wire logic clock_pin_stop_bit,
  input wire logic memory_clock_pin_stop_bit,
  input wire logic clock_divide_select_hi,
  input wire logic clock_divide_select_lo,
  // Port direction and data of the two pins
  input wire logic clock_pin_dir,
  input wire logic mem_pin_dir,
  input wire logic shared_port_chip_select_pin,
  input wire logic mem_if_present,
  // Transfer controller halt requests and activity
  input wire logic halt_write,
  input wire logic halt_write_by_core,
  input wire logic halt_req_a,
  input wire logic halt_req_b,
  input wire logic data_transfer_controller_busy,
  input wire logic external_dma_controller_busy,
  // Interrupt source clear requests of the two controllers
  input wire logic irq_clear_req_a,
  input wire logic irq_clear_req_b,
  // Pins
  output cpo_pkg::cpo_pin_type clock_pin,
  output cpo_pkg::cpo_pin_type mem_clock_pin,
  // Divided clock tick for peripherals and status
  output logic periph_tick,
  output logic transfer_ctrl_halt_bit_a,
  output logic transfer_ctrl_halt_bit_b,
  output logic irq_clear_ack_a,
  output logic irq_clear_ack_b
);
  import cpo_pkg::*;

  // Synchronised hardware standby pin, low means standby
  logic hw_stby_b;
  // Divider counter and divide select
  logic [CPO_DIV_W-1:0] div_q;
  logic [CPO_DIV_W-1:0] div_d;
  logic [CPO_SEL_W-1:0] sel;
  // Divided clock level and its end-of-period mask
  logic phi;
  logic [CPO_DIV_W-1:0] tick_mask;
  logic tick_q;
  logic tick_d;
  // Stop bits as taken at the end of a bus cycle
  logic clock_pin_stop_bit_q;
  logic clock_pin_stop_bit_d;
  logic mstop_q;
  logic mstop_d;
  // Shared port level held through software standby
  logic port_hold_q;
  logic port_hold_d;
  // Pin registers
  cpo_pin_type clk_pin_q;
  cpo_pin_type clk_pin_d;
  cpo_pin_type mem_pin_q;
  cpo_pin_type mem_pin_d;
  // Halt bits and interrupt clear answers
  logic halt_a_q;
  logic halt_a_d;
  logic halt_b_q;
  logic halt_b_d;
  logic ack_a_q;
  logic ack_a_d;
  logic ack_b_q;
  logic ack_b_d;
  // Effective standby: standby pin low or state input in hardware standby
  logic in_hw_stby;

  // Standby pin comes from outside the clock domain
  cpo_sync u_hw_stby_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(hw_standby_pin_b),
    .sync_out(hw_stby_b)
  );

  assign sel = {clock_divide_select_hi, clock_divide_select_lo};
  assign in_hw_stby = !hw_stby_b || (proc_state == CPO_HW_STBY);

  // Divider: counter bit sel gives clock divided by 2 to 16
  always_comb
  begin
    div_d = div_q + 4'h1;
    phi = div_q[sel];
    tick_mask = CPO_DIV_W'((5'h02 << sel) - 5'h01);
    tick_d = ((div_q & tick_mask) == tick_mask);
  end

  // Stop bits take effect only at a bus cycle boundary
  always_comb
  begin
    clock_pin_stop_bit_d = clock_pin_stop_bit_q;
    mstop_d = mstop_q;
    if (bus_cycle_end)
    begin
      clock_pin_stop_bit_d = clock_pin_stop_bit;
      mstop_d = memory_clock_pin_stop_bit;
    end
  end

  // System clock pin per direction, stop and state
  always_comb
  begin
    clk_pin_d = '{out: 1'b1, oe_b: 1'b0};
    if (!clock_pin_dir || in_hw_stby)
    begin
      clk_pin_d = '{out: 1'b1, oe_b: 1'b1};
    end
    else if (clock_pin_stop_bit_q || proc_state == CPO_SW_STBY)
    begin
      clk_pin_d = '{out: 1'b1, oe_b: 1'b0};
    end
    else
    begin
      clk_pin_d = '{out: phi, oe_b: 1'b0};
    end
  end

  // Memory clock pin; port level frozen in software standby
  always_comb
  begin
    port_hold_d = port_hold_q;
    if (proc_state != CPO_SW_STBY)
    begin
      port_hold_d = shared_port_chip_select_pin;
    end
    mem_pin_d = '{out: 1'b1, oe_b: 1'b1};
    if (in_hw_stby)
    begin
      mem_pin_d = '{out: 1'b1, oe_b: 1'b1};
    end
    else if (!mem_if_present || mstop_q)
    begin
      mem_pin_d = '{out: port_hold_q, oe_b: !mem_pin_dir};
    end
    else if (proc_state == CPO_SW_STBY)
    begin
      mem_pin_d = '{out: 1'b0, oe_b: 1'b0};
    end
    else
    begin
      mem_pin_d = '{out: phi, oe_b: 1'b0};
    end
  end

  // Transfer controller halt bits and interrupt clear gating
  always_comb
  begin
    halt_a_d = halt_a_q;
    halt_b_d = halt_b_q;
    if (halt_write && halt_write_by_core)
    begin
      if (!halt_req_a || !data_transfer_controller_busy)
      begin
        halt_a_d = halt_req_a;
      end
      if (!halt_req_b || !external_dma_controller_busy)
      begin
        halt_b_d = halt_req_b;
      end
    end
    ack_a_d = irq_clear_req_a && !halt_a_q;
    ack_b_d = irq_clear_req_b && !halt_b_q;
  end

  // Register every group; halts start cleared, pins released
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= CPO_DIV_RESET;
      tick_q <= 1'b0;
      clock_pin_stop_bit_q <= 1'b0;
      mstop_q <= 1'b0;
      port_hold_q <= 1'b0;
      clk_pin_q <= CPO_PIN_RESET;
      mem_pin_q <= CPO_PIN_RESET;
      halt_a_q <= 1'b0;
      halt_b_q <= 1'b0;
      ack_a_q <= 1'b0;
      ack_b_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
      clock_pin_stop_bit_q <= clock_pin_stop_bit_d;
      mstop_q <= mstop_d;
      port_hold_q <= port_hold_d;
      clk_pin_q <= clk_pin_d;
      mem_pin_q <= mem_pin_d;
      halt_a_q <= halt_a_d;
      halt_b_q <= halt_b_d;
      ack_a_q <= ack_a_d;
      ack_b_q <= ack_b_d;
    end
  end

  // Outputs straight from flip-flops
  assign clock_pin = clk_pin_q;
  assign mem_clock_pin = mem_pin_q;
  assign periph_tick = tick_q;
  assign transfer_ctrl_halt_bit_a = halt_a_q;
  assign transfer_ctrl_halt_bit_b = halt_b_q;
  assign irq_clear_ack_a = ack_a_q;
  assign irq_clear_ack_b = ack_b_q;
endmodule

// File: cpo_asserts.sv
/*
  Checker for the clock pin block, bound to its ports.
  Assumes inputs change just after rising edges of clk.
*/
`timescale 1ns/1ps
module cpo_asserts
(
  // Clock, reset and controls
  input wire logic clk,
  input wire logic rst_b,
  input wire cpo_pkg::cpo_state_type proc_state,
  input wire logic bus_cycle_end,
  // Standby pin, low means hardware standby after two synchroniser edges
  input wire logic hw_standby_pin_b,
  input wire logic clock_pin_stop_bit,
  input wire logic memory_clock_pin_stop_bit,
  input wire logic clock_pin_dir,
  input wire logic mem_pin_dir,
  input wire logic mem_if_present,
  // Watched pins
  input wire cpo_pkg::cpo_pin_type clock_pin,
  input wire cpo_pkg::cpo_pin_type mem_clock_pin
);
  import cpo_pkg::*;
  // One domain; checks sleep while in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  stop_high_a: assert property (
    bus_cycle_end && clock_pin_stop_bit ##1 clock_pin_dir &&
    proc_state != CPO_HW_STBY && $past(hw_standby_pin_b, 2)
    |=> clock_pin == 2'h2) else $error("not high");
  dir_float_a: assert property (
    !clock_pin_dir |=> clock_pin.oe_b) else $error("pin driven");
  sw_high_a: assert property (
    clock_pin_dir && proc_state == CPO_SW_STBY &&
    $past(hw_standby_pin_b, 2) |=> clock_pin == 2'h2)
    else $error("pin not high");
  hw_float_a: assert property (
    proc_state == CPO_HW_STBY |=> clock_pin.oe_b && mem_clock_pin.oe_b)
    else $error("pin not floating");
  mem_float_a: assert property (
    bus_cycle_end && memory_clock_pin_stop_bit ##1 !mem_pin_dir
    |=> mem_clock_pin.oe_b) else $error("pin driven");
  mem_out_a: assert property (
    bus_cycle_end && !memory_clock_pin_stop_bit && mem_if_present ##1
    mem_if_present && !mem_pin_dir && proc_state == CPO_NORMAL &&
    $past(hw_standby_pin_b, 2)
    |=> !mem_clock_pin.oe_b) else $error("clock not driven");
  mem_low_a: assert property (
    bus_cycle_end && !memory_clock_pin_stop_bit && mem_if_present ##1
    mem_if_present && proc_state == CPO_SW_STBY &&
    $past(hw_standby_pin_b, 2)
    |=> mem_clock_pin == 2'h0) else $error("pin not low");
  port_pin_a: assert property (
    !mem_if_present && !mem_pin_dir |=> mem_clock_pin.oe_b)
    else $error("pin driven");
endmodule
bind cpo_clock_pin_output_control cpo_asserts chk (.*);

// File: cpo_clk_rx.sv
/*
  Far-side device clocked from the system clock pin.
  Assumes it samples on the bench clock.
*/
`timescale 1ns/1ps
module cpo_clk_rx
(
  // Clock and watched pin
  input wire logic clk,
  input wire cpo_pkg::cpo_pin_type pin,
  // Cycles between rising edges
  output int period
);
  import cpo_pkg::*;
  int n = 0;
  logic last = 1'b1;
  // Count cycles between rising edges of the driven pin
  always @(posedge clk)
  begin
    n = n + 1;
    if (pin.oe_b)
    begin
      // No pull on the line: it reads as the inverse of its last level,
      // and no period is known until it is driven again
      last = !last;
      period = 0;
      n = 0;
    end
    else
    begin
      if (pin.out && !last)
      begin
        period = n;
        n = 0;
      end
      last = pin.out;
    end
  end
endmodule

// File: clock_pin_output_control_bench.sv
/*
  Self-checking bench for the clock pin block: random and corner cases.
  Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
module clock_pin_output_control_bench;
  import cpo_pkg::*;
  // Named as the ports, so the instance connects by name
  logic clk = 0, rst_b = 0, hw_standby_pin_b = 1;
  logic bus_cycle_end, clock_pin_stop_bit, memory_clock_pin_stop_bit;
  logic clock_divide_select_hi, clock_divide_select_lo, clock_pin_dir;
  logic mem_pin_dir, shared_port_chip_select_pin, mem_if_present;
  logic halt_write, halt_write_by_core, halt_req_a, halt_req_b;
  logic data_transfer_controller_busy, external_dma_controller_busy;
  logic irq_clear_req_a, irq_clear_req_b, periph_tick;
  logic transfer_ctrl_halt_bit_a, transfer_ctrl_halt_bit_b;
  logic irq_clear_ack_a, irq_clear_ack_b;
  cpo_state_type proc_state;
  cpo_pin_type clock_pin, mem_clock_pin;
  int period, failures = 0, n_compared = 0, seed = 84, r;
  // Bench copies of the state that the block keeps between edges
  logic clock_pin_stop_bit_m = 1'b0, mstop_m = 1'b0, port_m = 1'b0;
  logic halt_a_m = 1'b0, halt_b_m = 1'b0;
  logic ack_a_m, ack_b_m;
  // Expected pin codes and tick count
  logic [1:0] want_c, want_m;
  int ticks;
  cpo_clock_pin_output_control dut (.*);
  cpo_clk_rx rx (.clk(clk), .pin(clock_pin), .period(period));
  always #10 clk = ~clk;
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pin code: 0 or 1 driven level, 2 released, 3 clock running
  task chk_pin(input cpo_pin_type got, input logic [1:0] want);
    n_compared++;
    if (want[1] ? got.oe_b !== !want[0] : got !== {want[0], 1'b0})
    begin
      failures++;
      $display("MISMATCH %0t pin got %b want %0d", $time, got, want);
    end
  endtask
  // Expected system clock pin for the inputs taken at one edge
  function automatic logic [1:0] clk_pin_want(input logic dir, stop,
    input cpo_state_type st);
    if (!dir || st == CPO_HW_STBY)
      return 2'h2;
    if (stop || st == CPO_SW_STBY)
      return 2'h1;
    return 2'h3;
  endfunction
  // Expected memory clock pin; a stopped or absent interface is a port
  function automatic logic [1:0] mem_pin_want(input logic present, stop,
    dir, port, input cpo_state_type st);
    if (st == CPO_HW_STBY)
      return 2'h2;
    if (!present || stop)
      return dir ? {1'b0, port} : 2'h2;
    if (st == CPO_SW_STBY)
      return 2'h0;
    return 2'h3;
  endfunction
  // Random controls; only legal processing states
  task rnd;
    r = $random(seed);
    {bus_cycle_end, clock_pin_stop_bit, memory_clock_pin_stop_bit,
      clock_divide_select_lo, clock_pin_dir, mem_pin_dir, mem_if_present,
      shared_port_chip_select_pin, halt_write, halt_write_by_core,
      halt_req_a, halt_req_b, data_transfer_controller_busy,
      external_dma_controller_busy, irq_clear_req_a,
      irq_clear_req_b} = r[15:0];
    clock_divide_select_hi = 1'b0;
    proc_state = cpo_state_type'(3'(r[31:16] % 5));
  endtask
  task give_verdict;
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Tests need about 12 us; a hang is cut well after
  initial
  begin
    #200us;
    failures++;
    give_verdict;
  end
  initial
  begin
    rnd;
    cyc(5);
    chk(8'(clock_pin), 8'h3);
    rst_b = 1;
    repeat (500)
    begin
      rnd;
      // Expectations for the edge that takes these inputs
      want_c = clk_pin_want(clock_pin_dir, clock_pin_stop_bit_m, proc_state);
      want_m = mem_pin_want(mem_if_present, mstop_m, mem_pin_dir,
        port_m, proc_state);
      ack_a_m = irq_clear_req_a && !halt_a_m;
      ack_b_m = irq_clear_req_b && !halt_b_m;
      // Stop bits count only at a bus cycle end
      if (bus_cycle_end)
      begin
        clock_pin_stop_bit_m = clock_pin_stop_bit;
        mstop_m = memory_clock_pin_stop_bit;
      end
      // Port level frozen through software standby
      if (proc_state != CPO_SW_STBY)
        port_m = shared_port_chip_select_pin;
      // writes by other masters are left out of the halt bits
      if (halt_write && halt_write_by_core)
      begin
        if (!halt_req_a || !data_transfer_controller_busy)
          halt_a_m = halt_req_a;
        if (!halt_req_b || !external_dma_controller_busy)
          halt_b_m = halt_req_b;
      end
      cyc(1);
      chk_pin(clock_pin, want_c);
      chk_pin(mem_clock_pin, want_m);
      chk(8'(transfer_ctrl_halt_bit_a), 8'(halt_a_m));
      chk(8'(transfer_ctrl_halt_bit_b), 8'(halt_b_m));
      chk(8'({irq_clear_ack_a, irq_clear_ack_b}), 8'({ack_a_m, ack_b_m}));
    end
    // Standby pin low while state is normal
    {clock_pin_stop_bit, memory_clock_pin_stop_bit, mem_pin_dir} = 3'h2;
    {bus_cycle_end, irq_clear_req_a, hw_standby_pin_b} = 3'h4;
    proc_state = CPO_NORMAL;
    cyc(6);
    chk(8'({clock_pin.oe_b, mem_clock_pin.oe_b}), 8'h3);
    {hw_standby_pin_b, clock_pin_stop_bit, clock_pin_dir} = 3'h5;
    cyc(6);
    // Clock period seen by the far side for divide by 2 and divide by 4
    for (int s = 0; s < 2; s++)
    begin
      clock_divide_select_lo = s[0];
      ticks = 0;
      // One peripheral tick per divided period
      repeat (40)
      begin
        cyc(1);
        ticks += periph_tick;
      end
      chk(8'(period), 8'(2 << s));
      chk(8'(ticks), 8'(40 >> (s + 1)));
    end
    give_verdict;
  end
endmodule
